// file: rtl/sse_pkg.sv
// Constants and types for the skip and system control executor
// Notes on behaviour
// - Accumulator decrement-and-skip subtracts one; a zero result skips the next instruction.
// - Memory increment-and-skip adds one, writes back, skips next when zero.
// - Memory decrement-and-skip subtracts one, writes back, skips next when zero.
// - All three skip arithmetic ops update zero, carry, aux carry, overflow flags.
// - Call pushes next address at stack pointer, jumps anywhere, stack pointer plus two.
// - Jump loads program counter with any program address and continues there.
// - Return-with-value loads its immediate into accumulator, then returns normally.
// - Return lowers stack pointer by two, reloads program counter from that slot.
// - Interrupt return resumes the program and sets global interrupt enable.
// - Relative jump sets program counter to itself plus unsigned accumulator.
// - Global enable sets the interrupt enable so requests reach the CPU.
// - Global disable clears the interrupt enable so requests are blocked.
// - Full halt stops all clocks including oscillators.
// - CPU halt gates the system clock but leaves oscillators running.
// - Software reset clears all executor state like hardware reset, but leaves the bus front end unreset.
// - Watchdog clear restarts the watchdog count.
// - Control instructions other than software reset leave zero, carry, aux carry and overflow flags unchanged.
// - Call, jump, relative jump, returns take two cycles; plain others take one.
// - Skip instructions take two cycles when skipping and one when not.
package sse_pkg;
  localparam int unsigned PCW = 12;
  localparam int unsigned MAW = 4;
  localparam int unsigned MEM_DEPTH = 16;
  typedef logic [7:0] sse_acc_t;
  typedef logic [PCW-1:0] sse_pc_t;
  typedef logic [MAW-1:0] sse_sp_t;
  typedef logic [3:0] sse_flags_t;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] A_CMD = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_ACC = 8'h08;
  localparam logic [7:0] A_PC = 8'h0c;
  localparam logic [7:0] A_SP = 8'h10;
  localparam logic [7:0] A_MADDR = 8'h14;
  localparam logic [7:0] A_MDATA = 8'h18;
  localparam int unsigned CMD_OP_LSB = 0;
  localparam int unsigned CMD_OPR_LSB = 8;
  localparam int unsigned CMD_TGT_LSB = 16;
  localparam int unsigned S_SKIP = 4;
  localparam int unsigned S_GIE = 5;
  localparam int unsigned S_CPUSTOP = 6;
  localparam int unsigned S_SYSSTOP = 7;
  localparam int unsigned S_BUSY = 8;
  localparam int unsigned W_WAKE = 0;
  localparam int unsigned F_Z = 0;
  localparam int unsigned F_C = 1;
  localparam int unsigned F_AC = 2;
  localparam int unsigned F_OV = 3;
  // ----------------------------------------
  // Reset values and steps
  // ----------------------------------------
  localparam sse_acc_t ACC_RST = 8'h00;
  localparam sse_pc_t PC_RST = 12'h000;
  localparam sse_sp_t SP_RST = 4'h0;
  localparam sse_flags_t FLAGS_RST = 4'h0;
  localparam sse_acc_t BYTE_ZERO = 8'h00;
  localparam sse_pc_t PC_ONE = 12'h001;
  localparam sse_sp_t SP_ONE = 4'h1;
  localparam sse_sp_t SP_STEP = 4'h2;
  localparam logic [8:0] ONE9 = 9'h001;
  localparam logic [4:0] ONE5 = 5'h01;
  localparam int unsigned HT_ACTIVE_BIT = 1;
  localparam logic RESP_OKAY = 1'b0;
  // ----------------------------------------
  // Opcodes and states
  // ----------------------------------------
  typedef enum logic [3:0] {
    OP_NOP = 4'h0, OP_DZSN_A = 4'h1, OP_IZSN_M = 4'h2, OP_DZSN_M = 4'h3,
    OP_CALL = 4'h4, OP_GOTO = 4'h5, OP_RETV = 4'h6, OP_RET = 4'h7,
    OP_RETI = 4'h8, OP_JREL = 4'h9, OP_GIE_ON = 4'ha, OP_GIE_OFF = 4'hb,
    OP_STOPSYS = 4'hc, OP_STOPCPU = 4'hd, OP_SWRST = 4'he, OP_WDCLR = 4'hf
  } sse_op_e;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } sse_st_e;
endpackage

// file: rtl/sse_regbus_if.sv
// Internal register strobe carrier between bus slave and executor
`timescale 1ns/1ps
`default_nettype none
interface sse_regbus_if;
  logic wr_en;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport bus (output wr_en, output addr, output wdata, input rdata);
  modport core (input wr_en, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// file: rtl/sse_incdec.sv
// Increment or decrement of one byte with its four flags
`timescale 1ns/1ps
`default_nettype none
module sse_incdec (
  input wire logic [7:0] a,
  input wire logic dec,
  output logic [7:0] res,
  output sse_pkg::sse_flags_t flags
);
  import sse_pkg::*;
  logic [8:0] sum9;
  logic [4:0] sum5;
  always_comb begin
    sum9 = dec ? ({1'b0, a} - ONE9) : ({1'b0, a} + ONE9);
    sum5 = dec ? ({1'b0, a[3:0]} - ONE5) : ({1'b0, a[3:0]} + ONE5);
    res = sum9[7:0];
    flags = FLAGS_RST;
    flags[F_Z] = (sum9[7:0] == BYTE_ZERO);
    // Carry doubles as borrow on decrement
    flags[F_C] = sum9[8];
    flags[F_AC] = sum5[4];
    flags[F_OV] = (a[7] == dec) && (a[7] != sum9[7]);
  end
endmodule
`default_nettype wire

// file: rtl/sse_ahb_slave.sv
// AHB-Lite slave front end for the executor registers
`timescale 1ns/1ps
`default_nettype none
module sse_ahb_slave (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  sse_regbus_if.bus rb
);
  import sse_pkg::*;
  logic take;
  logic wr_pend_r;
  logic rd_pend_r;
  logic [7:0] addr_r;
  // Only whole words are used; hsize is not checked
  assign take = hsel && htrans[HT_ACTIVE_BIT] && hready;
  assign rb.wr_en = wr_pend_r;
  assign rb.addr = addr_r;
  assign rb.wdata = hwdata;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r <= 8'h00;
    end else begin
      wr_pend_r <= take && hwrite;
      rd_pend_r <= take && !hwrite;
      if (take) begin
        addr_r <= haddr[7:0];
      end
    end
  end
  // One wait state on reads so a write just before is seen
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hrdata <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      hreadyout <= 1'b0;
    end else if (rd_pend_r) begin
      hreadyout <= 1'b1;
      hrdata <= rb.rdata;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= RESP_OKAY;
    end else begin
      hresp <= RESP_OKAY;
    end
  end
endmodule
`default_nettype wire

// file: rtl/sse_exec.sv
// Skip and system control instruction executor with AHB-Lite access
`timescale 1ns/1ps
`default_nettype none
module sse_exec (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic gie,
  output logic sys_stop,
  output logic cpu_stop,
  output logic chip_reset,
  output logic wdt_clear
);
  import sse_pkg::*;

  // ----------------------------------------
  // Bus front end
  // ----------------------------------------
  sse_regbus_if rb ();
  sse_ahb_slave u_slave (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .rb(rb)
  );

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  sse_acc_t acc_r;
  sse_pc_t pc_r;
  sse_sp_t sp_r;
  sse_sp_t maddr_r;
  sse_flags_t flags_r;
  sse_st_e st_r;
  logic skip_r;
  sse_acc_t mem_r [MEM_DEPTH];

  // ----------------------------------------
  // Decode of an issued command
  // ----------------------------------------
  sse_op_e op;
  sse_acc_t opr;
  sse_pc_t tgt;
  sse_sp_t m_idx;
  sse_sp_t spm2;
  sse_sp_t spm1;
  sse_sp_t spp1;
  sse_pc_t pc1;
  sse_pc_t ret_pc;
  sse_acc_t alu_in;
  sse_acc_t alu_res;
  sse_flags_t alu_flags;
  logic cmd_go;
  logic ex;
  logic skip_now;
  logic is_skipop;
  logic skip_hit;
  logic two_cyc;
  logic halted;

  assign op = sse_op_e'(rb.wdata[CMD_OP_LSB +: 4]);
  assign opr = rb.wdata[CMD_OPR_LSB +: 8];
  assign tgt = rb.wdata[CMD_TGT_LSB +: PCW];
  assign m_idx = opr[MAW-1:0];
  assign halted = sys_stop || cpu_stop;
  // Commands while busy, halted or resetting are dropped
  assign cmd_go = rb.wr_en && hit(rb.addr, A_CMD) && (st_r == ST_IDLE) && !halted && !chip_reset;
  assign skip_now = cmd_go && skip_r;
  assign ex = cmd_go && !skip_r;
  assign is_skipop = ex && (op == OP_DZSN_A || op == OP_IZSN_M || op == OP_DZSN_M);
  assign alu_in = (op == OP_DZSN_A) ? acc_r : mem_r[m_idx];
  assign skip_hit = is_skipop && alu_flags[F_Z];
  assign two_cyc = skip_hit || (ex && (op == OP_CALL || op == OP_GOTO || op == OP_JREL
    || op == OP_RET || op == OP_RETV || op == OP_RETI));
  assign pc1 = sse_pc_t'(pc_r + PC_ONE);
  assign spm2 = sse_sp_t'(sp_r - SP_STEP);
  assign spm1 = sse_sp_t'(spm2 + SP_ONE);
  assign spp1 = sse_sp_t'(sp_r + SP_ONE);
  assign ret_pc = {mem_r[spm1][PCW-9:0], mem_r[spm2]};

  sse_incdec u_alu (
    .a(alu_in),
    .dec(op != OP_IZSN_M),
    .res(alu_res),
    .flags(alu_flags)
  );

  // ----------------------------------------
  // Cycle sequencer
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= ST_IDLE;
    end else if (chip_reset) begin
      st_r <= ST_IDLE;
    end else begin
      case (st_r)
        ST_IDLE: begin
          if (two_cyc) begin
            st_r <= ST_WAIT;
          end
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Skip, accumulator and flags
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      skip_r <= 1'b0;
    end else if (chip_reset) begin
      skip_r <= 1'b0;
    end else if (skip_now) begin
      skip_r <= 1'b0;
    end else if (skip_hit) begin
      skip_r <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_r <= ACC_RST;
    end else if (chip_reset) begin
      acc_r <= ACC_RST;
    end else if (ex && op == OP_DZSN_A) begin
      acc_r <= alu_res;
    end else if (ex && op == OP_RETV) begin
      acc_r <= opr;
    end else if (rb.wr_en && hit(rb.addr, A_ACC) && st_r == ST_IDLE) begin
      acc_r <= rb.wdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_r <= FLAGS_RST;
    end else if (chip_reset) begin
      flags_r <= FLAGS_RST;
    end else if (is_skipop) begin
      flags_r <= alu_flags;
    end
  end

  // ----------------------------------------
  // Program counter and stack pointer
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pc_r <= PC_RST;
    end else if (chip_reset) begin
      pc_r <= PC_RST;
    end else if (skip_now) begin
      pc_r <= pc1;
    end else if (ex) begin
      case (op)
        OP_CALL, OP_GOTO: pc_r <= tgt;
        OP_RET, OP_RETV, OP_RETI: pc_r <= ret_pc;
        OP_JREL: pc_r <= sse_pc_t'(pc_r + {4'h0, acc_r});
        default: pc_r <= pc1;
      endcase
    end else if (rb.wr_en && hit(rb.addr, A_PC) && st_r == ST_IDLE) begin
      pc_r <= rb.wdata[PCW-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sp_r <= SP_RST;
    end else if (chip_reset) begin
      sp_r <= SP_RST;
    end else if (ex && op == OP_CALL) begin
      sp_r <= sse_sp_t'(sp_r + SP_STEP);
    end else if (ex && (op == OP_RET || op == OP_RETV || op == OP_RETI)) begin
      sp_r <= spm2;
    end else if (rb.wr_en && hit(rb.addr, A_SP) && st_r == ST_IDLE) begin
      sp_r <= rb.wdata[MAW-1:0];
    end
  end

  // ----------------------------------------
  // Data memory and its software window
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      maddr_r <= SP_RST;
    end else if (chip_reset) begin
      maddr_r <= SP_RST;
    end else if (rb.wr_en && hit(rb.addr, A_MADDR)) begin
      maddr_r <= rb.wdata[MAW-1:0];
    end
  end

  // Memory is cleared on reset too; real RAM would keep it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < MEM_DEPTH; i++) begin
        mem_r[i] <= BYTE_ZERO;
      end
    end else if (chip_reset) begin
      for (int i = 0; i < MEM_DEPTH; i++) begin
        mem_r[i] <= BYTE_ZERO;
      end
    end else if (ex && (op == OP_IZSN_M || op == OP_DZSN_M)) begin
      mem_r[m_idx] <= alu_res;
    end else if (ex && op == OP_CALL) begin
      mem_r[sp_r] <= pc1[7:0];
      mem_r[spp1] <= 8'(pc1[PCW-1:8]);
    end else if (rb.wr_en && hit(rb.addr, A_MDATA)) begin
      mem_r[maddr_r] <= rb.wdata[7:0];
    end
  end

  // ----------------------------------------
  // System control outputs
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gie <= 1'b0;
    end else if (chip_reset) begin
      gie <= 1'b0;
    end else if (ex && (op == OP_GIE_ON || op == OP_RETI)) begin
      gie <= 1'b1;
    end else if (ex && op == OP_GIE_OFF) begin
      gie <= 1'b0;
    end
  end

  // Halts leave only by a wake write or by reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sys_stop <= 1'b0;
      cpu_stop <= 1'b0;
    end else if (chip_reset) begin
      sys_stop <= 1'b0;
      cpu_stop <= 1'b0;
    end else if (ex && op == OP_STOPSYS) begin
      sys_stop <= 1'b1;
    end else if (ex && op == OP_STOPCPU) begin
      cpu_stop <= 1'b1;
    end else if (rb.wr_en && hit(rb.addr, A_STAT) && rb.wdata[W_WAKE]) begin
      sys_stop <= 1'b0;
      cpu_stop <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chip_reset <= 1'b0;
      wdt_clear <= 1'b0;
    end else begin
      chip_reset <= ex && op == OP_SWRST;
      wdt_clear <= ex && op == OP_WDCLR;
    end
  end

  // ----------------------------------------
  // Read back
  // ----------------------------------------
  always_comb begin
    rb.rdata = 32'h0000_0000;
    if (hit(rb.addr, A_STAT)) begin
      rb.rdata[3:0] = flags_r;
      rb.rdata[S_SKIP] = skip_r;
      rb.rdata[S_GIE] = gie;
      rb.rdata[S_CPUSTOP] = cpu_stop;
      rb.rdata[S_SYSSTOP] = sys_stop;
      rb.rdata[S_BUSY] = (st_r == ST_WAIT);
    end else if (hit(rb.addr, A_ACC)) begin
      rb.rdata[7:0] = acc_r;
    end else if (hit(rb.addr, A_PC)) begin
      rb.rdata[PCW-1:0] = pc_r;
    end else if (hit(rb.addr, A_SP)) begin
      rb.rdata[MAW-1:0] = sp_r;
    end else if (hit(rb.addr, A_MADDR)) begin
      rb.rdata[MAW-1:0] = maddr_r;
    end else if (hit(rb.addr, A_MDATA)) begin
      rb.rdata[7:0] = mem_r[maddr_r];
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_ACC_DEC: assert property (@(posedge hclk) disable iff (!hresetn)
    ex && op == OP_DZSN_A |=> acc_r == sse_acc_t'($past(acc_r) - SP_ONE))
    else $error("acc decrement wrong");
  AST_SKIP_SET: assert property (@(posedge hclk) disable iff (!hresetn)
    is_skipop && alu_res == BYTE_ZERO |=> skip_r && flags_r[F_Z] && st_r == ST_WAIT)
    else $error("zero result did not arm skip");
  AST_SKIP_NOP: assert property (@(posedge hclk) disable iff (!hresetn)
    skip_now |=> !skip_r && acc_r == $past(acc_r) && pc_r == sse_pc_t'($past(pc_r) + PC_ONE)
    && sp_r == $past(sp_r) && gie == $past(gie))
    else $error("skipped instruction had effect");
  AST_CALL: assert property (@(posedge hclk) disable iff (!hresetn)
    ex && op == OP_CALL |=> pc_r == $past(tgt) && sp_r == sse_sp_t'($past(sp_r) + SP_STEP)
    && mem_r[$past(sp_r)] == sse_acc_t'($past(pc1)))
    else $error("call wrong");
  AST_RET: assert property (@(posedge hclk) disable iff (!hresetn)
    ex && op == OP_RET |=> sp_r == sse_sp_t'($past(sp_r) - SP_STEP) && pc_r == $past(ret_pc))
    else $error("return wrong");
  AST_RETI_GIE: assert property (@(posedge hclk) disable iff (!hresetn)
    ex && op == OP_RETI |=> gie ##1 gie)
    else $error("interrupt return left gie clear");
  AST_GIE_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
    ex && op == OP_GIE_OFF |=> !gie)
    else $error("disable left gie set");
  AST_FLAGS_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
    ex && !is_skipop |=> flags_r == $past(flags_r))
    else $error("control op changed flags");
  AST_TWO_CYC: assert property (@(posedge hclk) disable iff (!hresetn)
    ex && op == OP_GOTO |=> st_r == ST_WAIT ##1 st_r == ST_IDLE)
    else $error("jump not two cycles");
  AST_ONE_CYC: assert property (@(posedge hclk) disable iff (!hresetn)
    is_skipop && !alu_flags[F_Z] |=> st_r == ST_IDLE && !skip_r)
    else $error("unskipped op took two cycles");
  AST_WDT: assert property (@(posedge hclk) disable iff (!hresetn)
    ex && op == OP_WDCLR |=> wdt_clear ##1 !wdt_clear)
    else $error("watchdog clear not one pulse");
  AST_SWRST: assert property (@(posedge hclk) disable iff (!hresetn)
    chip_reset |=> pc_r == PC_RST && acc_r == ACC_RST && !gie && sp_r == SP_RST)
    else $error("software reset incomplete");
endmodule
`default_nettype wire

// file: dv/sse_tb.sv
// Self-checking bench for the skip and system control executor
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sse_pkg::*;
  // ----------------------------------------
  // Signals and model state
  // ----------------------------------------
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic hready;
  logic hreadyout, hresp, gie, sys_stop, cpu_stop, chip_reset, wdt_clear;
  int num_errors = 0;
  int checks = 0;
  int cyc = 0;
  int seed = 75;
  int n_wd = 0;
  int n_rst = 0;
  int e_wd = 0;
  int e_rst = 0;
  int acc, pc, sp, fl, ge, sk, hs, hc, op, opr, tgt, idx, v;
  int mem[16];
  int tbl[5] = '{0, 1, 127, 128, 255};
  assign hready = hreadyout;
  always #12.5 hclk = ~hclk;
  sse_exec i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .gie(gie),
    .sys_stop(sys_stop), .cpu_stop(cpu_stop), .chip_reset(chip_reset),
    .wdt_clear(wdt_clear));
  // Pulses last one cycle, so they are counted at every edge
  always @(posedge hclk) begin
    cyc++;
    if (wdt_clear === 1'b1) n_wd++;
    if (chip_reset === 1'b1) n_rst++;
    if (cyc == 40000) begin
      num_errors++;
      summarize();
    end
  end
  // ----------------------------------------
  // Bus tasks and comparisons
  // ----------------------------------------
  task summarize;
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    chk({31'h0, hresp}, {31'h0, RESP_OKAY}, "hresp");
  endtask
  task wr(input logic [7:0] a, input int d);
    xfer(1'b1, a, d);
  endtask
  task rdc(input logic [7:0] a);
    xfer(1'b0, a, 32'h0);
  endtask
  // ----------------------------------------
  // Reference model and checks
  // ----------------------------------------
  task automatic exec(input int o, input int p, input int t);
    int m, r, p0;
    if (hs || hc) return; // Dropped while halted
    p0 = pc;
    pc = (pc + 1) & 'hfff;
    if (sk) begin
      sk = 0;
      return;
    end
    case (o)
      1, 2, 3: begin
        m = (o == 1) ? acc : mem[p & 15];
        r = ((o == 2) ? m + 1 : m - 1) & 255;
        if (o == 2) fl = ((m == 255) << 1) | (((m & 15) == 15) << 2) | ((m == 127) << 3);
        else fl = ((m == 0) << 1) | (((m & 15) == 0) << 2) | ((m == 128) << 3);
        fl = fl | (r == 0);
        if (o == 1) acc = r;
        else mem[p & 15] = r;
        sk = (r == 0);
      end
      4: begin
        mem[sp] = pc & 255;
        mem[(sp + 1) & 15] = pc >> 8;
        pc = t;
        sp = (sp + 2) & 15;
      end
      5: pc = t;
      6, 7, 8: begin
        if (o == 6) acc = p;
        sp = (sp - 2) & 15;
        pc = (mem[sp] | (mem[(sp + 1) & 15] << 8)) & 'hfff;
        if (o == 8) ge = 1;
      end
      9: pc = (p0 + acc) & 'hfff;
      10: ge = 1;
      11: ge = 0;
      12: hs = 1;
      13: hc = 1;
      14: begin
        {acc, pc, sp, fl, ge, sk, hs, hc} = '0;
        mem = '{default: 0};
        e_rst++;
      end
      15: e_wd++;
      default: ;
    endcase
  endtask
  task cmd(input int o, input int p, input int t);
    wr(A_CMD, {4'h0, t[11:0], p[7:0], 4'h0, o[3:0]});
    exec(o, p, t);
    repeat (2) @(posedge hclk);
  endtask
  task check_all(input int i);
    rdc(A_STAT);
    chk(rd, (hs << 7) | (hc << 6) | (ge << 5) | (sk << 4) | fl, "stat");
    rdc(A_ACC);
    chk(rd, acc, "acc");
    rdc(A_PC);
    chk(rd, pc, "pc");
    rdc(A_SP);
    chk(rd, sp, "sp");
    chk({31'h0, gie}, ge, "gie");
    chk({31'h0, sys_stop}, hs, "sys_stop");
    chk({31'h0, cpu_stop}, hc, "cpu_stop");
    chk(n_wd, e_wd, "wdt pulses");
    chk(n_rst, e_rst, "reset pulses");
    if (i >= 0) begin
      wr(A_MADDR, i);
      rdc(A_MDATA);
      chk(rd, mem[i], "mem");
    end
  endtask
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    check_all(-1);
    rdc(8'h40);
    chk(rd, 32'h0, "unmapped");
    $display("reset test done");
    // Halts and soft reset stay out of the random mix; they stop or clear everything
    repeat (300) begin
      op = $random(seed) & 15;
      if (op >= 12 && op <= 14) op = 0;
      opr = $random(seed) & 255;
      tgt = $random(seed) & 'hfff;
      idx = opr & 15;
      v = $random(seed) & 7;
      acc = (v < 5) ? tbl[v] : ($random(seed) & 255);
      v = $random(seed) & 7;
      v = (v < 5) ? tbl[v] : ($random(seed) & 255);
      wr(A_ACC, acc);
      wr(A_MADDR, idx);
      wr(A_MDATA, v);
      mem[idx] = v;
      cmd(op, opr, tgt);
      check_all(idx);
    end
    $display("random op test done");
    // A skip left pending would swallow the first halt
    cmd(0, 0, 0);
    for (int h = 12; h <= 13; h++) begin
      cmd(h, 0, 0);
      check_all(-1);
      cmd(ge ? 11 : 10, 0, 0);
      check_all(-1);
      wr(A_STAT, 1);
      hs = 0;
      hc = 0;
      wr(A_PC, 0);
      pc = 0;
      check_all(-1);
    end
    $display("halt test done");
    cmd(10, 0, 0);
    cmd(14, 0, 0);
    check_all(idx);
    $display("soft reset test done");
    summarize();
  end
endmodule
`default_nettype wire
